// file: hw/ofead_defines.svh
// Constants for the operand format and effective address decoder
`ifndef OFEAD_DEFINES_SVH
`define OFEAD_DEFINES_SVH

// ==========================================================
// Status word
`define OFEAD_SW_RESET 16'h2700
`define OFEAD_SW_WMASK 16'hB71F
`define OFEAD_CFB_MASK 16'h00FF

// ==========================================================
// Effective address fields
`define OFEAD_MODE_SPEC 3'h7
`define OFEAD_SPEC_ABS_S 3'h0
`define OFEAD_SPEC_ABS_L 3'h1
`define OFEAD_SPEC_PC_D16 3'h2
`define OFEAD_SPEC_PC_IDX 3'h3
`define OFEAD_SPEC_IMM 3'h4

// ==========================================================
// Category bit positions
`define OFEAD_CAT_DATA 3
`define OFEAD_CAT_MEM 2
`define OFEAD_CAT_CTRL 1
`define OFEAD_CAT_ALT 0

// ==========================================================
// Memory bus
`define OFEAD_LANES 4

`endif

// file: hw/ofead_pkg.sv
// Types shared by the operand format and address decoder
package ofead_pkg;
  typedef enum logic [1:0] {SZ_BIT, SZ_BYTE, SZ_WORD, SZ_LONG} ofead_size_t;
  typedef enum logic [3:0] {
    EA_DATA_DIR, EA_ADDR_DIR, EA_IND, EA_POSTINC, EA_PREDEC, EA_DISP, EA_IDX,
    EA_PC_DISP, EA_PC_IDX, EA_ABS_SHORT, EA_ABS_LONG, EA_IMM, EA_NONE
  } ofead_ea_kind_t;
endpackage : ofead_pkg

// file: hw/ofead_ea_if.sv
// Interface between the top block and the address mode decoder
`timescale 1ns/1ps
interface ofead_ea_if;
  logic [2:0] mode_field;
  logic [2:0] reg_field;
  ofead_pkg::ofead_ea_kind_t kind;
  logic [3:0] cat;
  logic bad_code;
  modport dec (input mode_field, input reg_field, output kind, output cat, output bad_code);
  modport user (output mode_field, output reg_field, input kind, input cat, input bad_code);
endinterface : ofead_ea_if

// file: hw/ofead_ea_decode.sv
// Effective address mode decoder with category attributes
`timescale 1ns/1ps
`include "ofead_defines.svh"
module ofead_ea_decode (
  ofead_ea_if.dec ea
);
  // ==========================================================
  // Mode and category decode
  always_comb begin
    ea.bad_code = 1'b0;
    ea.kind = ofead_pkg::EA_NONE;
    ea.cat = 4'h0;
    unique case (ea.mode_field)
      3'h0: begin
        ea.kind = ofead_pkg::EA_DATA_DIR;
        ea.cat = 4'h9;
      end
      3'h1: begin
        ea.kind = ofead_pkg::EA_ADDR_DIR;
        ea.cat = 4'h1;
      end
      3'h2: begin
        ea.kind = ofead_pkg::EA_IND;
        ea.cat = 4'hF;
      end
      3'h3: begin
        ea.kind = ofead_pkg::EA_POSTINC;
        ea.cat = 4'hD;
      end
      3'h4: begin
        ea.kind = ofead_pkg::EA_PREDEC;
        ea.cat = 4'hD;
      end
      3'h5: begin
        ea.kind = ofead_pkg::EA_DISP;
        ea.cat = 4'hF;
      end
      3'h6: begin
        ea.kind = ofead_pkg::EA_IDX;
        ea.cat = 4'hF;
      end
      `OFEAD_MODE_SPEC: begin
        unique case (ea.reg_field)
          `OFEAD_SPEC_ABS_S: begin
            ea.kind = ofead_pkg::EA_ABS_SHORT;
            ea.cat = 4'hE;
          end
          `OFEAD_SPEC_ABS_L: begin
            ea.kind = ofead_pkg::EA_ABS_LONG;
            ea.cat = 4'hE;
          end
          `OFEAD_SPEC_PC_D16: begin
            ea.kind = ofead_pkg::EA_PC_DISP;
            ea.cat = 4'hE;
          end
          `OFEAD_SPEC_PC_IDX: begin
            ea.kind = ofead_pkg::EA_PC_IDX;
            ea.cat = 4'hE;
          end
          `OFEAD_SPEC_IMM: begin
            ea.kind = ofead_pkg::EA_IMM;
            ea.cat = 4'hC;
          end
          default: begin
            ea.bad_code = 1'b1;
          end
        endcase
      end
    endcase
  end
endmodule : ofead_ea_decode

// file: hw/ofead_top.sv
// Operand sizing, register merge, status word, byte lanes and EA decode
`timescale 1ns/1ps
`include "ofead_defines.svh"
module ofead_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic src_valid,
  input wire ofead_pkg::ofead_size_t src_size,
  input wire logic src_is_addr,
  input wire logic dst_is_addr,
  input wire logic [31:0] src_value,
  output logic [31:0] src_operand,
  output logic src_size_err,
  input wire logic wb_valid,
  input wire ofead_pkg::ofead_size_t wb_size,
  input wire logic wb_to_addr,
  input wire logic [31:0] wb_result,
  input wire logic [31:0] wb_old,
  output logic wb_we,
  output logic [31:0] wb_data,
  output logic wb_err,
  input wire logic sw_wr,
  input wire logic sw_byte,
  input wire logic supervisor,
  input wire logic [15:0] sw_wr_data,
  output logic [15:0] sw_rd_data,
  output logic [15:0] processor_status_word,
  input wire logic mem_valid,
  input wire ofead_pkg::ofead_size_t mem_size,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_store,
  input wire logic [31:0] mem_lanes_in,
  output logic [3:0] mem_be,
  output logic [31:0] mem_wdata,
  output logic [31:0] mem_load,
  output logic mem_align_err,
  input wire logic [2:0] ea_mode_field,
  input wire logic [2:0] ea_reg_field,
  input wire logic [3:0] ea_need,
  output ofead_pkg::ofead_ea_kind_t ea_kind,
  output logic [2:0] ea_reg_num,
  output logic [3:0] ea_cat,
  output logic ea_alt_mem,
  output logic ea_data_alt,
  output logic ea_illegal
);
  // ==========================================================
  // Helpers
  function automatic logic [2:0] bytes_of(input ofead_pkg::ofead_size_t sz);
    unique case (sz)
      ofead_pkg::SZ_WORD: bytes_of = 3'h2;
      ofead_pkg::SZ_LONG: bytes_of = 3'h4;
      default: bytes_of = 3'h1;
    endcase
  endfunction : bytes_of

  function automatic logic misaligned(input ofead_pkg::ofead_size_t sz, input logic [1:0] off);
    unique case (sz)
      ofead_pkg::SZ_WORD: misaligned = off[0];
      ofead_pkg::SZ_LONG: misaligned = (off != 2'h0);
      default: misaligned = 1'b0;
    endcase
  endfunction : misaligned

  // ==========================================================
  // Source operand formatting
  logic [31:0] next_src_operand;
  logic next_src_size_err;

  always_comb begin
    next_src_operand = src_operand;
    next_src_size_err = 1'b0;
    if (src_valid) begin
      unique case (src_size)
        ofead_pkg::SZ_BYTE: begin
          next_src_operand = {24'h000000, src_value[7:0]};
          next_src_size_err = src_is_addr;
        end
        ofead_pkg::SZ_WORD: begin
          if (dst_is_addr) begin
            next_src_operand = {{16{src_value[15]}}, src_value[15:0]};
          end else begin
            next_src_operand = {16'h0000, src_value[15:0]};
          end
        end
        default: begin
          next_src_operand = src_value;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_operand <= 32'h00000000;
      src_size_err <= 1'b0;
    end else begin
      src_operand <= next_src_operand;
      src_size_err <= next_src_size_err;
    end
  end

  // ==========================================================
  // Register write merge
  logic [31:0] next_wb_data;
  logic next_wb_we;
  logic next_wb_err;

  always_comb begin
    next_wb_data = wb_data;
    next_wb_we = 1'b0;
    next_wb_err = 1'b0;
    if (wb_valid) begin
      next_wb_we = 1'b1;
      if (wb_to_addr) begin
        unique case (wb_size)
          ofead_pkg::SZ_WORD: next_wb_data = {{16{wb_result[15]}}, wb_result[15:0]};
          ofead_pkg::SZ_LONG: next_wb_data = wb_result;
          default: begin
            next_wb_we = 1'b0;
            next_wb_err = 1'b1;
          end
        endcase
      end else begin
        unique case (wb_size)
          ofead_pkg::SZ_BYTE: next_wb_data = {wb_old[31:8], wb_result[7:0]};
          ofead_pkg::SZ_WORD: next_wb_data = {wb_old[31:16], wb_result[15:0]};
          default: next_wb_data = wb_result;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_data <= 32'h00000000;
      wb_we <= 1'b0;
      wb_err <= 1'b0;
    end else begin
      wb_data <= next_wb_data;
      wb_we <= next_wb_we;
      wb_err <= next_wb_err;
    end
  end

  // ==========================================================
  // Status word and flag byte
  logic [15:0] next_psw;
  logic [15:0] next_sw_rd_data;

  always_comb begin
    next_psw = processor_status_word;
    if (sw_wr) begin
      if (sw_byte || !supervisor) begin
        next_psw = (processor_status_word & ~`OFEAD_CFB_MASK)
                 | (sw_wr_data & `OFEAD_CFB_MASK & `OFEAD_SW_WMASK);
      end else begin
        next_psw = sw_wr_data & `OFEAD_SW_WMASK;
      end
    end
    if (sw_byte) begin
      next_sw_rd_data = processor_status_word & `OFEAD_CFB_MASK;
    end else begin
      next_sw_rd_data = processor_status_word;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      processor_status_word <= `OFEAD_SW_RESET;
      sw_rd_data <= 16'h0000;
    end else begin
      processor_status_word <= next_psw;
      sw_rd_data <= next_sw_rd_data;
    end
  end

  // ==========================================================
  // Big-endian byte lanes
  logic [1:0] lane_off;
  logic [2:0] lane_n;
  logic [4:0] lane_shift;
  logic lane_bad;
  logic [3:0] lane_be;
  logic [31:0] next_mem_wdata;
  logic [31:0] next_mem_load;
  logic [3:0] next_mem_be;
  logic next_mem_align_err;

  assign lane_off = mem_addr[1:0];
  assign lane_n = bytes_of(mem_size);
  assign lane_bad = misaligned(mem_size, lane_off);
  // Lowest address sits in bits 31:24
  assign lane_shift = {3'(3'h4 - {1'b0, lane_off} - lane_n), 2'h0} << 1;

  genvar gi;
  generate
    for (gi = 0; gi < `OFEAD_LANES; gi++) begin : g_lane
      assign lane_be[gi] = (3'(gi) >= {1'b0, lane_off})
                         && (3'(gi) < 3'({1'b0, lane_off} + lane_n));
    end
  endgenerate

  always_comb begin
    next_mem_be = 4'h0;
    next_mem_wdata = mem_wdata;
    next_mem_load = mem_load;
    next_mem_align_err = 1'b0;
    if (mem_valid) begin
      next_mem_align_err = lane_bad;
      if (!lane_bad) begin
        next_mem_be = {lane_be[0], lane_be[1], lane_be[2], lane_be[3]};
        next_mem_wdata = mem_store << lane_shift;
        unique case (mem_size)
          ofead_pkg::SZ_LONG: next_mem_load = mem_lanes_in;
          ofead_pkg::SZ_WORD: next_mem_load = {16'h0000, 16'(mem_lanes_in >> lane_shift)};
          default: next_mem_load = {24'h000000, 8'(mem_lanes_in >> lane_shift)};
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_be <= 4'h0;
      mem_wdata <= 32'h00000000;
      mem_load <= 32'h00000000;
      mem_align_err <= 1'b0;
    end else begin
      mem_be <= next_mem_be;
      mem_wdata <= next_mem_wdata;
      mem_load <= next_mem_load;
      mem_align_err <= next_mem_align_err;
    end
  end

  // ==========================================================
  // Effective address decode
  ofead_ea_if ea_bus ();
  ofead_ea_decode u_ea_decode (.ea(ea_bus));
  assign ea_bus.mode_field = ea_mode_field;
  assign ea_bus.reg_field = ea_reg_field;

  logic next_alt_mem;
  logic next_data_alt;
  logic next_illegal;
  logic [2:0] next_reg_num;

  always_comb begin
    next_alt_mem = ea_bus.cat[`OFEAD_CAT_ALT] && ea_bus.cat[`OFEAD_CAT_MEM];
    next_data_alt = ea_bus.cat[`OFEAD_CAT_ALT] && ea_bus.cat[`OFEAD_CAT_DATA];
    next_illegal = ea_bus.bad_code || ((ea_need & ~ea_bus.cat) != 4'h0);
    next_reg_num = (ea_mode_field == `OFEAD_MODE_SPEC) ? 3'h0 : ea_reg_field;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ea_kind <= ofead_pkg::EA_NONE;
      ea_reg_num <= 3'h0;
      ea_cat <= 4'h0;
      ea_alt_mem <= 1'b0;
      ea_data_alt <= 1'b0;
      ea_illegal <= 1'b0;
    end else begin
      ea_kind <= ea_bus.kind;
      ea_reg_num <= next_reg_num;
      ea_cat <= ea_bus.cat;
      ea_alt_mem <= next_alt_mem;
      ea_data_alt <= next_data_alt;
      ea_illegal <= next_illegal;
    end
  end

  // ==========================================================
  // Checks
  property p_byte_addr;
    @(posedge clk) disable iff (!rst_n)
    src_valid && src_is_addr && src_size == ofead_pkg::SZ_BYTE |=> src_size_err;
  endproperty
  a_byte_addr: assert property (p_byte_addr) else $error("byte addr source not flagged");

  property p_sext;
    @(posedge clk) disable iff (!rst_n)
    src_valid && dst_is_addr && src_size == ofead_pkg::SZ_WORD
    |=> src_operand == {{16{$past(src_value[15])}}, $past(src_value[15:0])};
  endproperty
  a_sext: assert property (p_sext) else $error("word source not sign-extended");

  property p_merge;
    @(posedge clk) disable iff (!rst_n)
    wb_valid && !wb_to_addr && wb_size == ofead_pkg::SZ_BYTE
    |=> wb_we && wb_data == {$past(wb_old[31:8]), $past(wb_result[7:0])};
  endproperty
  a_merge: assert property (p_merge) else $error("byte merge wrong");

  property p_addr_full;
    @(posedge clk) disable iff (!rst_n)
    wb_valid && wb_to_addr && wb_size == ofead_pkg::SZ_WORD
    |=> wb_data[31:16] == {16{$past(wb_result[15])}};
  endproperty
  a_addr_full: assert property (p_addr_full) else $error("addr write not full");

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
    (processor_status_word & ~`OFEAD_SW_WMASK) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_cfb;
    @(posedge clk) disable iff (!rst_n)
    sw_wr && sw_byte ##1 1'b1
    |-> processor_status_word[15:8] == $past(processor_status_word[15:8]);
  endproperty
  a_cfb: assert property (p_cfb) else $error("flag byte write changed upper");

  property p_word_order;
    @(posedge clk) disable iff (!rst_n)
    mem_valid && mem_size == ofead_pkg::SZ_WORD && mem_addr[1:0] == 2'h0
    |=> mem_be == 4'hC && mem_wdata[31:24] == $past(mem_store[15:8]);
  endproperty
  a_word_order: assert property (p_word_order) else $error("word byte order");

  property p_long_order;
    @(posedge clk) disable iff (!rst_n)
    mem_valid && mem_size == ofead_pkg::SZ_LONG && mem_addr[1:0] == 2'h0
    |=> mem_be == 4'hF && mem_wdata[31:16] == $past(mem_store[31:16]);
  endproperty
  a_long_order: assert property (p_long_order) else $error("long half order");

  property p_bad_spec;
    @(posedge clk) disable iff (!rst_n)
    ea_mode_field == 3'h7 && ea_reg_field > 3'h4 |=> ea_illegal;
  endproperty
  a_bad_spec: assert property (p_bad_spec) else $error("bad special not flagged");

  property p_pc_alter;
    @(posedge clk) disable iff (!rst_n)
    ea_kind == ofead_pkg::EA_PC_DISP || ea_kind == ofead_pkg::EA_PC_IDX
    |-> !ea_cat[`OFEAD_CAT_ALT] && !ea_alt_mem && !ea_data_alt;
  endproperty
  a_pc_alter: assert property (p_pc_alter) else $error("pc mode alterable");
endmodule : ofead_top

// file: verif/ofead_partner.sv
// Register file model standing in for the pipeline side of write-back
`timescale 1ns/1ps
module ofead_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] sel,
  input wire logic we,
  input wire logic [31:0] wdata,
  output logic [31:0] old
);
  logic [31:0] regs [16];

  // ==========================================================
  // Storage: a known pattern at reset so merges are visible
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= 32'h8765_4300 | 32'(i);
      end
    end else if (we) begin
      regs[sel] <= wdata;
    end
  end

  assign old = regs[sel];
endmodule : ofead_partner

// file: verif/testbench.sv
// Self-checking testbench for the operand format and address decoder
`timescale 1ns/1ps
module testbench;
  logic clk, rst_n;
  logic src_valid, src_is_addr, dst_is_addr, src_size_err;
  ofead_pkg::ofead_size_t src_size, wb_size, mem_size;
  logic [31:0] src_value, src_operand;
  logic wb_valid, wb_to_addr, wb_we, wb_err;
  logic [31:0] wb_result, wb_old, wb_data;
  logic [3:0] wb_sel;
  logic sw_wr, sw_byte, supervisor;
  logic [15:0] sw_wr_data, sw_rd_data, processor_status_word;
  logic mem_valid, mem_align_err;
  logic [31:0] mem_addr, mem_store, mem_lanes_in, mem_wdata, mem_load;
  logic [3:0] mem_be, ea_need, ea_cat;
  logic [2:0] ea_mode_field, ea_reg_field, ea_reg_num;
  ofead_pkg::ofead_ea_kind_t ea_kind;
  logic ea_alt_mem, ea_data_alt, ea_illegal;
  int error_cnt, samples_checked;

  ofead_top dut (.clk(clk), .rst_n(rst_n), .src_valid(src_valid), .src_size(src_size),
    .src_is_addr(src_is_addr), .dst_is_addr(dst_is_addr), .src_value(src_value),
    .src_operand(src_operand), .src_size_err(src_size_err), .wb_valid(wb_valid),
    .wb_size(wb_size), .wb_to_addr(wb_to_addr), .wb_result(wb_result), .wb_old(wb_old),
    .wb_we(wb_we), .wb_data(wb_data), .wb_err(wb_err), .sw_wr(sw_wr), .sw_byte(sw_byte),
    .supervisor(supervisor), .sw_wr_data(sw_wr_data), .sw_rd_data(sw_rd_data),
    .processor_status_word(processor_status_word), .mem_valid(mem_valid),
    .mem_size(mem_size), .mem_addr(mem_addr), .mem_store(mem_store),
    .mem_lanes_in(mem_lanes_in), .mem_be(mem_be), .mem_wdata(mem_wdata),
    .mem_load(mem_load), .mem_align_err(mem_align_err), .ea_mode_field(ea_mode_field),
    .ea_reg_field(ea_reg_field), .ea_need(ea_need), .ea_kind(ea_kind),
    .ea_reg_num(ea_reg_num), .ea_cat(ea_cat), .ea_alt_mem(ea_alt_mem),
    .ea_data_alt(ea_data_alt), .ea_illegal(ea_illegal));

  ofead_partner rf (.clk(clk), .rst_n(rst_n), .sel(wb_sel), .we(wb_we), .wdata(wb_data),
    .old(wb_old));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================
  // Shared helpers
  task automatic step();
    @(posedge clk);
    @(negedge clk);
  endtask : step

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Source operand formatting
  task automatic src_op(input ofead_pkg::ofead_size_t sz, input logic sa, input logic da,
                        input logic [31:0] v, input logic [31:0] exp, input logic err);
    src_valid = 1'b1;
    src_size = sz;
    src_is_addr = sa;
    dst_is_addr = da;
    src_value = v;
    step();
    check({31'h0, src_size_err}, {31'h0, err});
    if (!err) check(src_operand, exp);
  endtask : src_op

  task automatic test_source();
    src_op(ofead_pkg::SZ_BYTE, 1'b0, 1'b0, 32'h1234_5687, 32'h0000_0087, 1'b0);
    src_op(ofead_pkg::SZ_WORD, 1'b0, 1'b0, 32'h1234_5687, 32'h0000_5687, 1'b0);
    src_op(ofead_pkg::SZ_LONG, 1'b0, 1'b0, 32'h1234_5687, 32'h1234_5687, 1'b0);
    src_op(ofead_pkg::SZ_BIT, 1'b0, 1'b0, 32'h1234_5687, 32'h1234_5687, 1'b0);
    src_op(ofead_pkg::SZ_WORD, 1'b1, 1'b1, 32'h0000_8001, 32'hFFFF_8001, 1'b0);
    src_op(ofead_pkg::SZ_WORD, 1'b0, 1'b1, 32'hABCD_7001, 32'h0000_7001, 1'b0);
    src_op(ofead_pkg::SZ_WORD, 1'b1, 1'b0, 32'h7FFF_8001, 32'h0000_8001, 1'b0);
    src_op(ofead_pkg::SZ_LONG, 1'b1, 1'b1, 32'h7FFF_8001, 32'h7FFF_8001, 1'b0);
    src_op(ofead_pkg::SZ_BYTE, 1'b1, 1'b0, 32'h0000_0011, 32'h0000_0000, 1'b1);
    src_valid = 1'b0;
    step();
    check({31'h0, src_size_err}, 32'h0000_0000);
  endtask : test_source

  // ==========================================================
  // Register write-back merge
  task automatic wb_op(input ofead_pkg::ofead_size_t sz, input logic ta, input logic [3:0] sel,
                       input logic [31:0] res, input logic [31:0] exp, input logic err);
    wb_valid = 1'b1;
    wb_size = sz;
    wb_to_addr = ta;
    wb_sel = sel;
    wb_result = res;
    step();
    wb_valid = 1'b0;
    check({31'h0, wb_we}, {31'h0, !err});
    check({31'h0, wb_err}, {31'h0, err});
    if (!err) check(wb_data, exp);
    step();
    check(wb_old, exp);
  endtask : wb_op

  task automatic test_writeback();
    wb_op(ofead_pkg::SZ_BYTE, 1'b0, 4'h1, 32'hFFFF_FFAA, 32'h8765_43AA, 1'b0);
    wb_op(ofead_pkg::SZ_BYTE, 1'b0, 4'h1, 32'h0000_0055, 32'h8765_4355, 1'b0);
    wb_op(ofead_pkg::SZ_WORD, 1'b0, 4'h2, 32'hFFFF_1234, 32'h8765_1234, 1'b0);
    wb_op(ofead_pkg::SZ_LONG, 1'b0, 4'h3, 32'h1357_9BDF, 32'h1357_9BDF, 1'b0);
    wb_op(ofead_pkg::SZ_BIT, 1'b0, 4'h4, 32'h0000_0001, 32'h0000_0001, 1'b0);
    wb_op(ofead_pkg::SZ_WORD, 1'b1, 4'h9, 32'h0000_8001, 32'hFFFF_8001, 1'b0);
    wb_op(ofead_pkg::SZ_WORD, 1'b1, 4'hA, 32'hFFFF_7001, 32'h0000_7001, 1'b0);
    wb_op(ofead_pkg::SZ_LONG, 1'b1, 4'hB, 32'h1234_5678, 32'h1234_5678, 1'b0);
    wb_op(ofead_pkg::SZ_BYTE, 1'b1, 4'hC, 32'h0000_00FF, 32'h8765_430C, 1'b1);
    wb_op(ofead_pkg::SZ_BIT, 1'b1, 4'hD, 32'h0000_0001, 32'h8765_430D, 1'b1);
  endtask : test_writeback

  // ==========================================================
  // Status word and flag byte
  task automatic sw_op(input logic wr, input logic bt, input logic sup, input logic [15:0] d,
                       input logic [15:0] exp);
    sw_wr = wr;
    sw_byte = bt;
    supervisor = sup;
    sw_wr_data = d;
    step();
    check({16'h0, processor_status_word}, {16'h0, exp});
    if (!wr) check({16'h0, sw_rd_data}, {16'h0, bt ? {8'h00, exp[7:0]} : exp});
  endtask : sw_op

  task automatic test_status();
    sw_op(1'b0, 1'b0, 1'b1, 16'h0000, 16'h2700);
    sw_op(1'b1, 1'b1, 1'b1, 16'hFFFF, 16'h271F);
    sw_op(1'b0, 1'b1, 1'b1, 16'h0000, 16'h271F);
    sw_op(1'b0, 1'b1, 1'b0, 16'h0000, 16'h271F);
    sw_op(1'b1, 1'b0, 1'b1, 16'hFFFF, 16'hB71F);
    sw_op(1'b0, 1'b0, 1'b1, 16'h0000, 16'hB71F);
    sw_op(1'b1, 1'b0, 1'b0, 16'h0000, 16'hB700);
    sw_op(1'b1, 1'b0, 1'b1, 16'h2704, 16'h2704);
    sw_op(1'b1, 1'b1, 1'b0, 16'h5A00, 16'h2700);
    sw_wr = 1'b0;
  endtask : test_status

  // ==========================================================
  // Memory byte lanes
  task automatic mem_op(input ofead_pkg::ofead_size_t sz, input logic [31:0] a,
                        input logic [31:0] st, input logic [3:0] be,
                        input logic [31:0] wd, input logic [31:0] ld);
    logic [31:0] m;
    mem_valid = 1'b1;
    mem_size = sz;
    mem_addr = a;
    mem_store = st;
    step();
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    check({28'h0, mem_be}, {28'h0, be});
    check({31'h0, mem_align_err}, {31'h0, be == 4'h0});
    check(mem_wdata & m, wd);
    if (be != 4'h0) check(mem_load, ld);
  endtask : mem_op

  task automatic test_memory();
    mem_op(ofead_pkg::SZ_LONG, 32'h0, 32'h1122_3344, 4'hF, 32'h1122_3344, 32'hA1B2_C3D4);
    mem_op(ofead_pkg::SZ_WORD, 32'h0, 32'h0000_5566, 4'hC, 32'h5566_0000, 32'h0000_A1B2);
    mem_op(ofead_pkg::SZ_WORD, 32'h2, 32'h0000_1234, 4'h3, 32'h0000_1234, 32'h0000_C3D4);
    mem_op(ofead_pkg::SZ_BYTE, 32'h1, 32'h0000_0077, 4'h4, 32'h0077_0000, 32'h0000_00B2);
    mem_op(ofead_pkg::SZ_BYTE, 32'h3, 32'h0000_0077, 4'h1, 32'h0000_0077, 32'h0000_00D4);
    mem_op(ofead_pkg::SZ_LONG, 32'h4, 32'hCAFE_0001, 4'hF, 32'hCAFE_0001, 32'hA1B2_C3D4);
    mem_op(ofead_pkg::SZ_WORD, 32'h1, 32'h0000_1234, 4'h0, 32'h0, 32'h0);
    mem_op(ofead_pkg::SZ_LONG, 32'h2, 32'h1122_3344, 4'h0, 32'h0, 32'h0);
    mem_valid = 1'b0;
  endtask : test_memory

  // ==========================================================
  // Effective address decode over every field and need mask
  task automatic test_ea();
    logic [3:0] cat_tab [8];
    ofead_pkg::ofead_ea_kind_t spec_k [5];
    logic [3:0] cat;
    logic bad;
    ofead_pkg::ofead_ea_kind_t kind;
    cat_tab = '{4'h9, 4'h1, 4'hF, 4'hD, 4'hD, 4'hF, 4'hF, 4'hE};
    spec_k = '{ofead_pkg::EA_ABS_SHORT, ofead_pkg::EA_ABS_LONG, ofead_pkg::EA_PC_DISP,
               ofead_pkg::EA_PC_IDX, ofead_pkg::EA_IMM};
    for (int md = 0; md < 8; md++) begin
      for (int rg = 0; rg < 8; rg++) begin
        for (int nd = 0; nd < 16; nd++) begin
          ea_mode_field = 3'(md);
          ea_reg_field = 3'(rg);
          ea_need = 4'(nd);
          step();
          bad = (md == 7) && (rg > 4);
          cat = (md == 7 && rg == 4) ? 4'hC : cat_tab[md];
          kind = (md < 7) ? ofead_pkg::ofead_ea_kind_t'(md) : spec_k[rg % 5];
          check({31'h0, ea_illegal}, {31'h0, bad || ((4'(nd) & ~cat) != 4'h0)});
          if (!bad) begin
            check({28'h0, ea_kind}, {28'h0, kind});
            check({29'h0, ea_reg_num}, {29'h0, md < 7 ? 3'(rg) : 3'h0});
            check({28'h0, ea_cat}, {28'h0, cat});
            check({30'h0, ea_alt_mem, ea_data_alt},
                  {30'h0, cat[0] & cat[2], cat[3] & cat[0]});
          end
        end
      end
    end
  endtask : test_ea

  // ==========================================================
  // Main sequence
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    src_valid = 1'b0;
    src_size = ofead_pkg::SZ_LONG;
    src_is_addr = 1'b0;
    dst_is_addr = 1'b0;
    src_value = 32'h0;
    wb_valid = 1'b0;
    wb_size = ofead_pkg::SZ_LONG;
    wb_to_addr = 1'b0;
    wb_result = 32'h0;
    wb_sel = 4'h0;
    sw_wr = 1'b0;
    sw_byte = 1'b0;
    supervisor = 1'b1;
    sw_wr_data = 16'h0;
    mem_valid = 1'b0;
    mem_size = ofead_pkg::SZ_LONG;
    mem_addr = 32'h0;
    mem_store = 32'h0;
    mem_lanes_in = 32'hA1B2_C3D4;
    ea_mode_field = 3'h0;
    ea_reg_field = 3'h0;
    ea_need = 4'h0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check({16'h0, processor_status_word}, 32'h0000_2700);
    check({28'h0, ea_kind}, {28'h0, ofead_pkg::EA_NONE});
    rst_n = 1'b1;
    test_source();
    test_writeback();
    test_status();
    test_memory();
    test_ea();
    end_of_test();
  end

  initial begin
    #500000;
    error_cnt++;
    end_of_test();
  end
endmodule : testbench
